/* rtl/uart_fifo_lin_pkg.sv */
// Package: constants and types of the FIFO serial port with LIN break.
// Assumes a byte-wide register port with 16-bit addresses.
package uart_fifo_lin_pkg;
	// ----------------------------------------
	// Register addresses
	// ----------------------------------------
	localparam logic [15:0] ADDR_FIFO = 16'h00A5;
	localparam logic [15:0] ADDR_DATA = 16'h00A6;
	localparam logic [15:0] ADDR_IRQ = 16'h00A7;
	localparam logic [15:0] ADDR_CFG = 16'h00C2;
	localparam logic [15:0] ADDR_LIN_CTRL = 16'hA090;
	localparam logic [15:0] ADDR_LCNT_HI = 16'hA091;
	localparam logic [15:0] ADDR_LCNT_LO = 16'hA092;
	localparam logic [15:0] ADDR_DIV_HI = 16'hA093;
	localparam logic [15:0] ADDR_DIV_LO = 16'hA094;
	// ----------------------------------------
	// Reset values and counts
	// ----------------------------------------
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [15:0] DIV_RESET = 16'h0000;
	localparam logic [3:0] FIFO_DEPTH = 4'hF;
	localparam logic [3:0] RX_FLUSH_CODE = 4'hF;
	localparam logic [3:0] TX_FLUSH_CODE = 4'h0;
	localparam logic [4:0] BREAK_BASE = 5'h0D;
	localparam logic [3:0] CHAR_BASE = 4'h4;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int FLG_TRA = 6;
	localparam int FLG_RDA = 5;
	localparam int FLG_RFO = 4;
	localparam int FLG_RFU = 3;
	localparam int FLG_TFO = 2;
	localparam int FLG_FRAMING_ERROR_FLAG = 1;
	localparam int FLG_TI = 0;
	localparam int LIN_EN_BIT = 7;
	localparam int LIN_MASTER_BIT = 6;
	localparam int LIN_SBK_BIT = 3;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP, TX_BRK, TX_DELIM}
		tx_state_t;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_t;
	typedef struct packed {
		logic parity_error_status;
		logic [7:0] data;
	} rx_entry_t;
endpackage : uart_fifo_lin_pkg

/* rtl/uart_fifo_lin_controller.sv */
// FIFO serial port with programmable thresholds and LIN break sending.
// Assumes one 125 MHz clock, a synchronous reset and a byte register port.
// Summary of operation
// - Separate 15-byte transmit and receive queues, each with its own threshold.
// - Own 16-bit baud divider, independent of other timers.
// - Bit rate is clock divided by divider; zero divider is forbidden.
// - Serial enable runs transmit and receive; clear stops the receiver and new queued transmit frames.
// - Stop-bit select gives two stop bits, else one.
// - Length codes 00..11 give 5..8 data bits, parity excluded.
// - Break bit holds serial output low until software clears it.
// - Parity enable turns parity on; read shows head byte parity error.
// - Forced parity sends parity bit as one.
// - Status read gives rx count high, tx count low; writes set thresholds.
// - Receive available when rx count exceeds rx threshold 0..14.
// - Rx threshold code 1111 resets receiver and empties rx queue.
// - Transmit ready when tx count below tx threshold 1..15.
// - Tx threshold code 0000 resets transmitter and empties tx queue.
// - Divider low bits zero with enable clear empties queues, clears overflow and underflow flags.
// - Interrupt needs global enable and individually enabled flag; global resets off.
// - Transmit ready clears itself once count is not below threshold.
// - Receive available also set after idle over threshold times 16 bits.
// - Receive available clears by writing zero when count below threshold.
// - Overflow and underflow flags sticky; write zero or queue reset clears.
// - Framing error flag on bad stop bit; cleared by writing zero.
// - Transmit complete flag when all bytes sent; cleared by writing zero.
// - Data read pops receive queue; data write pushes transmit queue.
// - Ordinary port keeps working while LIN is enabled.
// - Break command sends 13 plus extra dominant bits, one recessive, self-clears.
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module uart_fifo_lin_controller (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// Register port
	input wire logic [15:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	// Serial line and interrupt
	input wire logic rx_i,
	output logic tx_o,
	output logic irq_o
);
	import uart_fifo_lin_pkg::*;

	function automatic logic [3:0] inc_ptr(input logic [3:0] p);
		inc_ptr = (p == FIFO_DEPTH - 4'h1) ? 4'h0 : p + 4'h1;
	endfunction : inc_ptr

	function automatic logic par_of(input logic [7:0] d, input logic [1:0] len,
		input logic odd);
		logic [7:0] m;
		m = 8'hFF >> (2'h3 - len);
		par_of = (^(d & m)) ^ odd;
	endfunction : par_of

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0] cfg_ff;
	logic pe_ff;
	logic [3:0] rx_thr_ff, tx_thr_ff;
	logic [15:0] div_ff;
	logic gie_ff;
	logic [6:0] en_ff, flg_ff;
	logic lin_en_ff, lin_master_ff, sbk_ff;
	logic [2:0] brk_extra_ff;
	logic [15:0] lcnt_ff;
	logic [7:0] rdata_ff;
	logic irq_ff, txd_ff;

	wire ser_en = cfg_ff[7];
	wire two_stop = cfg_ff[6];
	wire [1:0] len_sel = cfg_ff[5:4];
	wire brk_bit = cfg_ff[3];
	wire odd_sel = cfg_ff[2];
	wire force_one = cfg_ff[0];
	wire wr_fifo = wr_i && addr_i == ADDR_FIFO;
	wire wr_data = wr_i && addr_i == ADDR_DATA;
	wire wr_irq = wr_i && addr_i == ADDR_IRQ;
	wire rd_data = rd_i && addr_i == ADDR_DATA;
	wire fifo_clr = !ser_en && div_ff[11:0] == 12'h000;
	wire rx_flush = fifo_clr || (wr_fifo && wdata_i[7:4] == RX_FLUSH_CODE);
	wire tx_flush = fifo_clr || (wr_fifo && wdata_i[3:0] == TX_FLUSH_CODE);

	// ----------------------------------------
	// Baud tick
	// ----------------------------------------
	logic [15:0] baud_ff;
	wire tick = baud_ff >= div_ff - 16'h0001;
	always_ff @(posedge clock_i) begin
		if (rst_i || tick)
			baud_ff <= 16'h0000;
		else
			baud_ff <= baud_ff + 16'h0001;
	end

	// ----------------------------------------
	// Queues
	// ----------------------------------------
	logic [7:0] tx_mem [0:14];
	rx_entry_t rx_mem [0:14];
	logic [3:0] tx_wp_ff, tx_rp_ff, tx_cnt_ff, rx_wp_ff, rx_rp_ff, rx_cnt_ff;
	logic tx_pop, rx_push;
	rx_entry_t rx_new;
	// push on write, pop on read
	wire tx_push = wr_data && tx_cnt_ff != FIFO_DEPTH;
	wire rx_pop = rd_data && rx_cnt_ff != 4'h0;
	wire rx_put = rx_push && rx_cnt_ff != FIFO_DEPTH;

	always_ff @(posedge clock_i) begin
		if (tx_push)
			tx_mem[tx_wp_ff] <= wdata_i;
		if (rst_i || tx_flush) begin
			tx_wp_ff <= 4'h0;
			tx_rp_ff <= 4'h0;
			tx_cnt_ff <= 4'h0;
		end else begin
			if (tx_push)
				tx_wp_ff <= inc_ptr(tx_wp_ff);
			if (tx_pop)
				tx_rp_ff <= inc_ptr(tx_rp_ff);
			tx_cnt_ff <= tx_cnt_ff + {3'h0, tx_push} - {3'h0, tx_pop};
		end
	end

	always_ff @(posedge clock_i) begin
		if (rx_put)
			rx_mem[rx_wp_ff] <= rx_new;
		if (rst_i || rx_flush) begin
			rx_wp_ff <= 4'h0;
			rx_rp_ff <= 4'h0;
			rx_cnt_ff <= 4'h0;
		end else begin
			if (rx_put)
				rx_wp_ff <= inc_ptr(rx_wp_ff);
			if (rx_pop)
				rx_rp_ff <= inc_ptr(rx_rp_ff);
			rx_cnt_ff <= rx_cnt_ff + {3'h0, rx_put} - {3'h0, rx_pop};
		end
	end

	// ----------------------------------------
	// Transmitter
	// ----------------------------------------
	tx_state_t tx_st_ff;
	logic [7:0] tx_sh_ff;
	logic tx_par_ff;
	logic [4:0] tx_bit_ff;
	logic tx_done;
	// break only in enabled master mode
	wire brk_go = sbk_ff && lin_en_ff && lin_master_ff;
	assign tx_pop = tx_st_ff == TX_IDLE && tick && !brk_go && ser_en && tx_cnt_ff != 4'h0
		&& !tx_flush;

	always_ff @(posedge clock_i) begin
		tx_done <= 1'b0;
		if (rst_i || tx_flush) begin
			tx_st_ff <= TX_IDLE;
			tx_bit_ff <= 5'h00;
			tx_sh_ff <= 8'h00;
			tx_par_ff <= 1'b0;
		end else if (tick) begin
			case (tx_st_ff)
				TX_IDLE: begin
					tx_bit_ff <= 5'h00;
					if (brk_go)
						tx_st_ff <= TX_BRK;
					else if (tx_pop) begin
						tx_sh_ff <= tx_mem[tx_rp_ff];
						tx_par_ff <= par_of(tx_mem[tx_rp_ff], len_sel, odd_sel);
						tx_st_ff <= TX_START;
					end
				end
				TX_START: tx_st_ff <= TX_DATA;
				TX_DATA: begin
					tx_sh_ff <= tx_sh_ff >> 1;
					tx_bit_ff <= tx_bit_ff + 5'h01;
					if (tx_bit_ff[3:0] == CHAR_BASE + {2'h0, len_sel}) begin
						tx_bit_ff <= 5'h00;
						tx_st_ff <= pe_ff ? TX_PAR : TX_STOP;
					end
				end
				TX_PAR: tx_st_ff <= TX_STOP;
				TX_STOP: begin
					tx_bit_ff <= 5'h01;
					if (!two_stop || tx_bit_ff[0]) begin
						tx_st_ff <= TX_IDLE;
						tx_done <= tx_cnt_ff == 4'h0;
					end
				end
				TX_BRK: begin
					tx_bit_ff <= tx_bit_ff + 5'h01;
					if (tx_bit_ff == BREAK_BASE + {2'h0, brk_extra_ff} - 5'h01)
						tx_st_ff <= TX_DELIM;
				end
				TX_DELIM: tx_st_ff <= TX_IDLE;
				default: tx_st_ff <= TX_IDLE;
			endcase
		end
	end

	logic line;
	always_comb begin
		case (tx_st_ff)
			TX_START, TX_BRK: line = 1'b0;
			TX_DATA: line = tx_sh_ff[0];
			TX_PAR: line = force_one | tx_par_ff;
			default: line = 1'b1;
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (rst_i)
			txd_ff <= 1'b1;
		else
			txd_ff <= brk_bit ? 1'b0 : line;
	end

	// ----------------------------------------
	// Receiver
	// ----------------------------------------
	logic rx_m_ff, rxd_ff;
	rx_state_t rx_st_ff;
	logic [15:0] rx_tmr_ff;
	logic [3:0] rx_bit_ff;
	logic [7:0] rx_sh_ff;
	logic rx_par_ff;
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			rx_m_ff <= 1'b1;
			rxd_ff <= 1'b1;
		end else begin
			rx_m_ff <= rx_i;
			rxd_ff <= rx_m_ff;
		end
	end

	wire rx_smp = rx_st_ff != RX_IDLE && rx_tmr_ff == 16'h0000;
	assign rx_push = rx_st_ff == RX_STOP && rx_smp;
	wire [7:0] rx_data = rx_sh_ff >> (2'h3 - len_sel);
	// parity check; forced parity expects a one
	assign rx_new = '{parity_error_status: pe_ff && (force_one ? !rx_par_ff
		: rx_par_ff != par_of(rx_data, len_sel, odd_sel)), data: rx_data};

	always_ff @(posedge clock_i) begin
		if (rst_i || rx_flush || !ser_en) begin
			rx_st_ff <= RX_IDLE;
			rx_tmr_ff <= 16'h0000;
			rx_bit_ff <= 4'h0;
			rx_sh_ff <= 8'h00;
			rx_par_ff <= 1'b0;
		end else if (rx_st_ff == RX_IDLE) begin
			rx_bit_ff <= 4'h0;
			if (!rxd_ff) begin
				rx_st_ff <= RX_START;
				rx_tmr_ff <= div_ff >> 1;
			end
		end else if (!rx_smp)
			rx_tmr_ff <= rx_tmr_ff - 16'h0001;
		else begin
			rx_tmr_ff <= div_ff - 16'h0001;
			case (rx_st_ff)
				RX_START: rx_st_ff <= rxd_ff ? RX_IDLE : RX_DATA;
				RX_DATA: begin
					rx_sh_ff <= {rxd_ff, rx_sh_ff[7:1]};
					rx_bit_ff <= rx_bit_ff + 4'h1;
					if (rx_bit_ff == CHAR_BASE + {2'h0, len_sel})
						rx_st_ff <= pe_ff ? RX_PAR : RX_STOP;
				end
				RX_PAR: begin
					rx_par_ff <= rxd_ff;
					rx_st_ff <= RX_STOP;
				end
				default: rx_st_ff <= RX_IDLE;
			endcase
		end
	end

	logic [7:0] idle_ff;
	always_ff @(posedge clock_i) begin
		if (rst_i || rx_st_ff != RX_IDLE || !rxd_ff)
			idle_ff <= 8'h00;
		else if (tick && idle_ff != 8'hFF)
			idle_ff <= idle_ff + 8'h01;
	end
	// One pulse as the limit is passed, so a clearing write can stick
	wire idle_hit = tick && rx_st_ff == RX_IDLE && rxd_ff && idle_ff == {rx_thr_ff, 4'h0}
		&& rx_cnt_ff != 4'h0 && rx_cnt_ff < rx_thr_ff;

	// ----------------------------------------
	// Flags and interrupt
	// ----------------------------------------
	logic [6:0] set_v;
	always_comb begin
		set_v = 7'h00;
		set_v[FLG_RDA] = rx_cnt_ff > rx_thr_ff || idle_hit;
		set_v[FLG_RFO] = rx_push && rx_cnt_ff == FIFO_DEPTH;
		set_v[FLG_RFU] = rd_data && rx_cnt_ff == 4'h0;
		set_v[FLG_TFO] = wr_data && tx_cnt_ff == FIFO_DEPTH;
		set_v[FLG_FRAMING_ERROR_FLAG] = rx_push && !rxd_ff;
		set_v[FLG_TI] = tx_done;
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			flg_ff <= 7'h00;
			en_ff <= 7'h00;
			gie_ff <= 1'b0;
		end else begin
			for (int i = 0; i < 7; i++) begin
				// Set wins over a clearing write
				if (set_v[i])
					flg_ff[i] <= 1'b1;
				else if (wr_irq && !wdata_i[i] && (i != FLG_RDA || rx_cnt_ff < rx_thr_ff))
					flg_ff[i] <= 1'b0;
			end
			if (fifo_clr) begin
				flg_ff[FLG_RFO] <= set_v[FLG_RFO];
				flg_ff[FLG_RFU] <= set_v[FLG_RFU];
				flg_ff[FLG_TFO] <= set_v[FLG_TFO];
			end
			flg_ff[FLG_TRA] <= tx_cnt_ff < tx_thr_ff;
			if (wr_irq) begin
				gie_ff <= wdata_i[7];
				en_ff <= wdata_i[6:0];
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i)
			irq_ff <= 1'b0;
		else
			irq_ff <= gie_ff && |(flg_ff & en_ff);
	end

	// ----------------------------------------
	// Configuration writes
	// ----------------------------------------
	// reset defaults
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			cfg_ff <= REG_RESET;
			pe_ff <= 1'b0;
			rx_thr_ff <= 4'h0;
			tx_thr_ff <= 4'h0;
			div_ff <= DIV_RESET;
		end else if (wr_i) begin
			case (addr_i)
				ADDR_CFG: begin
					cfg_ff <= wdata_i;
					pe_ff <= wdata_i[1];
				end
				ADDR_FIFO: begin
					if (wdata_i[7:4] != RX_FLUSH_CODE)
						rx_thr_ff <= wdata_i[7:4];
					if (wdata_i[3:0] != TX_FLUSH_CODE)
						tx_thr_ff <= wdata_i[3:0];
				end
				ADDR_DIV_HI: div_ff[15:8] <= wdata_i;
				ADDR_DIV_LO: div_ff[7:0] <= wdata_i;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			lin_en_ff <= 1'b0;
			lin_master_ff <= 1'b0;
			sbk_ff <= 1'b0;
			brk_extra_ff <= 3'h0;
		end else begin
			if (wr_i && addr_i == ADDR_LIN_CTRL) begin
				lin_en_ff <= wdata_i[LIN_EN_BIT];
				if (!lin_en_ff)
					lin_master_ff <= wdata_i[LIN_MASTER_BIT];
				brk_extra_ff <= wdata_i[2:0];
			end
			if (wr_i && addr_i == ADDR_LIN_CTRL && wdata_i[LIN_SBK_BIT])
				sbk_ff <= 1'b1;
			else if (!lin_en_ff || (tx_st_ff == TX_DELIM && tick))
				sbk_ff <= 1'b0;
		end
	end

	// Counts baud ticks; cleared by break start and queue clear
	always_ff @(posedge clock_i) begin
		if (rst_i || fifo_clr || (tx_st_ff == TX_IDLE && tick && brk_go))
			lcnt_ff <= 16'h0000;
		else if (tick)
			lcnt_ff <= lcnt_ff + 16'h0001;
	end

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	always_ff @(posedge clock_i) begin
		if (rst_i)
			rdata_ff <= 8'h00;
		else if (rd_i) begin
			case (addr_i)
				ADDR_CFG: rdata_ff <= {cfg_ff[7:2], rx_mem[rx_rp_ff].parity_error_status && rx_cnt_ff != 4'h0,
					cfg_ff[0]};
				ADDR_FIFO: rdata_ff <= {rx_cnt_ff, tx_cnt_ff};
				ADDR_IRQ: rdata_ff <= {gie_ff, flg_ff};
				ADDR_DATA: rdata_ff <= rx_cnt_ff != 4'h0 ? rx_mem[rx_rp_ff].data : 8'h00;
				ADDR_LIN_CTRL: rdata_ff <= {lin_en_ff, lin_master_ff, 2'h0, sbk_ff, brk_extra_ff};
				ADDR_LCNT_HI: rdata_ff <= lcnt_ff[15:8];
				ADDR_LCNT_LO: rdata_ff <= lcnt_ff[7:0];
				default: rdata_ff <= 8'h00;
			endcase
		end
	end

	assign rdata_o = rdata_ff;
	assign tx_o = txd_ff;
	assign irq_o = irq_ff;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	brk_low_a: assert property (@(posedge clock_i) disable iff (rst_i)
		brk_bit |=> !tx_o) else $error("break bit did not hold line low");
	irq_gate_a: assert property (@(posedge clock_i) disable iff (rst_i)
		!gie_ff |=> !irq_o) else $error("interrupt without global enable");
	rx_flush_a: assert property (@(posedge clock_i) disable iff (rst_i)
		(wr_fifo && wdata_i[7:4] == 4'hF) |=> rx_cnt_ff == 4'h0) else $error("rx not flushed");
	tx_flush_a: assert property (@(posedge clock_i) disable iff (rst_i)
		(wr_fifo && wdata_i[3:0] == 4'h0) |=> tx_cnt_ff == 4'h0 && tx_st_ff == TX_IDLE)
		else $error("tx not flushed");
	fifo_clear_a: assert property (@(posedge clock_i) disable iff (rst_i)
		fifo_clr && !wr_data && !rd_data |=> !flg_ff[FLG_RFO] && !flg_ff[FLG_TFO]
		&& rx_cnt_ff == 4'h0) else $error("queue clear incomplete");
	tra_level_a: assert property (@(posedge clock_i) disable iff (rst_i)
		##1 flg_ff[FLG_TRA] == $past(tx_cnt_ff < tx_thr_ff)) else $error("tx ready wrong");
	frame_err_a: assert property (@(posedge clock_i) disable iff (rst_i)
		rx_push && !rxd_ff |=> flg_ff[FLG_FRAMING_ERROR_FLAG]) else $error("framing error missed");
	forced_par_a: assert property (@(posedge clock_i) disable iff (rst_i)
		tx_st_ff == TX_PAR && force_one && !brk_bit |=> tx_o) else $error("parity not one");
	rda_set_a: assert property (@(posedge clock_i) disable iff (rst_i)
		rx_cnt_ff > rx_thr_ff |=> flg_ff[FLG_RDA]) else $error("rx available missed");
endmodule : uart_fifo_lin_controller
`default_nettype wire

/* verification/serial_peer_model.sv */
// Remote serial node: sends frames into the port and decodes its output.
// Assumes the bench sets div, nbits, par_on and stops while the line is idle.
`timescale 1ns/1ps
`default_nettype none
module serial_peer_model (
	// Clock
	input wire logic clock_i,
	// Serial line
	input wire logic line_i,
	output logic line_o
);
	int div = 8;
	int nbits = 8;
	bit par_on = 1'b0;
	int stops = 1;
	logic [7:0] got_q[$];
	logic got_par_q[$];
	logic got_stop_q[$];
	logic prev = 1'b1;
	logic [7:0] d;
	initial line_o = 1'b1;
	task automatic clear;
		got_q.delete();
		got_par_q.delete();
		got_stop_q.delete();
	endtask : clear
	// ----------------------------------------
	// Sender
	// ----------------------------------------
	// bit time and length
	task automatic send(input logic [7:0] v, input logic par, input logic stopv);
		line_o <= 1'b0;
		repeat (div) @(posedge clock_i);
		for (int i = 0; i < nbits; i++) begin
			line_o <= v[i];
			repeat (div) @(posedge clock_i);
		end
		if (par_on) begin
			line_o <= par;
			repeat (div) @(posedge clock_i);
		end
		line_o <= stopv;
		repeat (div) @(posedge clock_i);
		line_o <= 1'b1;
		repeat (2 * div) @(posedge clock_i);
	endtask : send
	// ----------------------------------------
	// Decoder
	// ----------------------------------------
	// Sampled on the falling edge, away from the port's own updates
	initial forever begin
		@(negedge clock_i);
		if (prev && !line_i) begin
			d = 8'h00;
			repeat (div / 2) @(negedge clock_i);
			for (int i = 0; i < nbits; i++) begin
				repeat (div) @(negedge clock_i);
				d[i] = line_i;
			end
			if (par_on) begin
				repeat (div) @(negedge clock_i);
				got_par_q.push_back(line_i);
			end
			for (int s = 0; s < stops; s++) begin
				repeat (div) @(negedge clock_i);
				got_stop_q.push_back(line_i);
			end
			got_q.push_back(d);
		end
		prev = line_i;
	end
endmodule : serial_peer_model
`default_nettype wire

/* verification/tb.sv */
// Self-checking bench for the FIFO serial port with LIN break.
// Assumes the peer model on both serial pins and a divider of 8.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import uart_fifo_lin_pkg::*;
	localparam int DIV = 8;
	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	logic [15:0] addr_i = 16'h0000;
	logic [7:0] wdata_i = 8'h00;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [7:0] rdata_o;
	logic rx_i;
	logic tx_o;
	logic irq_o;
	int bad_count = 0;
	int compares = 0;
	int pm;
	int k;
	int n;
	logic [7:0] exp_q[$];
	logic [7:0] d;
	logic [7:0] v;
	logic [7:0] cfg;
	logic [7:0] rb[3];

	uart_fifo_lin_controller i_dut (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rx_i(rx_i),
		.tx_o(tx_o), .irq_o(irq_o));
	serial_peer_model i_peer (.clock_i(clock_i), .line_i(tx_o), .line_o(rx_i));

	initial forever #4 clock_i = ~clock_i;
	// ----------------------------------------
	// Bus and check tasks
	// ----------------------------------------
	task automatic wr(input logic [15:0] a, input logic [7:0] x);
		@(posedge clock_i);
		addr_i <= a;
		wdata_i <= x;
		wr_i <= 1'b1;
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [15:0] a);
		@(posedge clock_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clock_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask : rd
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic rchk(input logic [15:0] a, input logic [7:0] exp);
		rd(a);
		chk(d, exp);
	endtask : rchk
	task automatic wrap_up;
		if (bad_count == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : wrap_up
	task automatic wait_rx(input int cnt);
		for (k = 0; i_peer.got_q.size() < cnt && k < 4000; k++) @(posedge clock_i);
		if (k == 4000) begin
			bad_count++;
			$display("CHECK FAILED at %0t: wait timed out", $time);
			wrap_up();
		end
	endtask : wait_rx
	// Parity modes: 0 none, 1 even, 2 odd, 3 forced one
	function automatic logic par_bit(input logic [7:0] x, input int mode);
		return (mode == 3) ? 1'b1 : ((^x) ^ (mode == 2));
	endfunction : par_bit
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(32'h4200));
		repeat (2) @(posedge clock_i);
		rst_i <= 1'b0;
		rchk(ADDR_CFG, 8'h00);
		rchk(ADDR_FIFO, 8'h00);
		rchk(ADDR_IRQ, 8'h00);
		rchk(16'h1234, 8'h00);
		chk({irq_o, tx_o}, 8'h01);
		wr(ADDR_DIV_HI, 8'h00);
		wr(ADDR_DIV_LO, DIV[7:0]);
		for (int m = 0; m < 8; m++) begin
			pm = (m + m / 4) % 4;
			i_peer.nbits = m % 4 + 5;
			i_peer.par_on = (pm != 0);
			i_peer.stops = m / 4 + 1;
			i_peer.clear();
			cfg = {1'b1, m[2], m[1:0], 1'b0, pm == 2, pm != 0, pm == 3};
			wr(ADDR_CFG, cfg);
			for (int j = 0; j < 3; j++) begin
				v = 8'($urandom);
				exp_q.push_back(v & (8'hFF >> (3 - m % 4)));
				wr(ADDR_DATA, v);
			end
			wait_rx(3);
			repeat (2 * DIV) @(posedge clock_i);
			foreach (i_peer.got_q[j]) begin
				v = exp_q.pop_front();
				chk(i_peer.got_q[j], v);
				if (pm != 0) chk(i_peer.got_par_q[j], par_bit(v, pm));
			end
			foreach (i_peer.got_stop_q[j]) chk(i_peer.got_stop_q[j], 8'h01);
		end
		rchk(ADDR_IRQ, 8'h01);
		wr(ADDR_IRQ, 8'h00);
		rchk(ADDR_IRQ, 8'h00);
		i_peer.nbits = 8;
		i_peer.par_on = 1'b1;
		i_peer.stops = 1;
		wr(ADDR_CFG, 8'hB2);
		wr(ADDR_FIFO, 8'h01);
		for (int j = 0; j < 3; j++) begin
			rb[j] = 8'($urandom);
			i_peer.send(rb[j], par_bit(rb[j], 1) ^ (j == 1), j != 2);
		end
		rchk(ADDR_FIFO, 8'h30);
		rchk(ADDR_IRQ, 8'h62);
		rchk(ADDR_CFG, 8'hB0);
		rchk(ADDR_DATA, rb[0]);
		rd(ADDR_CFG);
		chk(d, 8'hB2);
		rd(ADDR_DATA);
		chk(d, rb[1]);
		rd(ADDR_DATA);
		rd(ADDR_DATA);
		chk(d, 8'h00);
		rchk(ADDR_IRQ, 8'h6A);
		wr(ADDR_FIFO, 8'h21);
		wr(ADDR_IRQ, 8'h00);
		rchk(ADDR_IRQ, 8'h40);
		i_peer.send(8'h3C, par_bit(8'h3C, 1), 1'b1);
		rchk(ADDR_FIFO, 8'h10);
		wr(ADDR_FIFO, 8'hF1);
		rchk(ADDR_FIFO, 8'h00);
		wr(ADDR_IRQ, 8'hA0);
		i_peer.send(8'hC3, par_bit(8'hC3, 1), 1'b1);
		chk(irq_o, 8'h00);
		for (n = 0; !irq_o && n < 40 * DIV; n++) @(negedge clock_i);
		chk(n >= 24 * DIV && n < 40 * DIV, 8'h01);
		wr(ADDR_IRQ, 8'h20);
		rchk(ADDR_IRQ, 8'h60);
		chk(irq_o, 8'h00);
		wr(ADDR_IRQ, 8'h80);
		rchk(ADDR_IRQ, 8'hC0);
		rd(ADDR_DATA);
		chk(d, 8'hC3);
		wr(ADDR_CFG, 8'h30);
		wr(ADDR_FIFO, 8'h2F);
		i_peer.clear();
		for (int j = 0; j < 15; j++) wr(ADDR_DATA, j[7:0]);
		rchk(ADDR_FIFO, 8'h0F);
		rchk(ADDR_IRQ, 8'h80);
		wr(ADDR_DATA, 8'hEE);
		wr(ADDR_IRQ, 8'h84);
		// Enable lands on one edge, the registered interrupt on the next
		repeat (2) @(negedge clock_i);
		chk(irq_o, 8'h01);
		rchk(ADDR_IRQ, 8'h84);
		wr(ADDR_FIFO, 8'h20);
		rchk(ADDR_FIFO, 8'h00);
		chk(i_peer.got_q.size(), 8'h00);
		wr(ADDR_DATA, 8'hA5);
		wr(ADDR_DIV_LO, 8'h00);
		rchk(ADDR_FIFO, 8'h00);
		rchk(ADDR_IRQ, 8'hC0);
		rchk(ADDR_LCNT_LO, 8'h00);
		chk(irq_o, 8'h00);
		wr(ADDR_DIV_LO, DIV[7:0]);
		wr(ADDR_CFG, 8'hB8);
		// Line register follows the config register one edge later
		@(posedge clock_i);
		n = 0;
		repeat (16 * DIV) begin
			@(negedge clock_i);
			n += !tx_o;
		end
		chk(n == 16 * DIV, 8'h01);
		wr(ADDR_CFG, 8'hB0);
		repeat (2 * DIV) @(posedge clock_i);
		chk(tx_o, 8'h01);
		i_peer.par_on = 1'b0;
		i_peer.clear();
		v = 8'($urandom);
		wr(ADDR_LIN_CTRL, 8'hCA);
		fork
			begin
				wr(ADDR_DATA, 8'h55);
				wr(ADDR_DATA, v);
			end
			begin
				@(negedge clock_i);
				for (k = 0; tx_o && k < 4 * DIV; k++) @(negedge clock_i);
				for (n = 0; !tx_o && n < 40 * DIV; n++) @(negedge clock_i);
			end
		join
		chk(n == 15 * DIV, 8'h01);
		wait_rx(3);
		chk(i_peer.got_q[1], 8'h55);
		chk(i_peer.got_q[2], v);
		rd(ADDR_LIN_CTRL);
		chk(d & 8'h08, 8'h00);
		wr(ADDR_LIN_CTRL, 8'h00);
		wrap_up();
	end
endmodule : tb
`default_nettype wire
